// ### logic/ohp_pkg.sv
// Constants, types and shared helpers for the single-wire debug host
// Contract
// - Frame: start, 8 data, even parity, 2 stops
// - Idle is twelve high bits, line resting
// - Sync 0x55 before instructions and after break
// - Wait for acknowledge after every store
// - Debugger alone starts transfers; sync sets baud
// - Keep baud within selected clock's range
// - Double break, stop bit between, resets always
// - Hold break for slowest recommended rate
// - Enable pulse low 200ns to 1us
// - Start sync within 13.5ms of release
// - High-voltage pulse forces port pin function
// - Disable bit ends session, drops clock
package ohp_pkg;

  localparam int CLK_MHZ = 125;
  localparam int EN_PULSE_NS = 400;
  localparam int EN_PULSE_CYC = (EN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int EN_WAIT_US = 300;
  localparam int SYNC_WINDOW_US = 13500;
  localparam int RX_WAIT_US = 2000;
  localparam int BREAK_US = 24600;
  localparam int BREAK_CYC = BREAK_US * CLK_MHZ;

  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam int SUBS_PER_BIT = 16;
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h9;
  localparam logic [3:0] SUB_LAST = 4'hf;

  // Register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_BRK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CFG = 8'h10;

  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RXV = 2;
  localparam int ST_ESTART = 3;
  localparam int ST_EPAR = 4;
  localparam int ST_ESTOP = 5;
  localparam int ST_TMO = 6;
  localparam int ST_LINE = 7;
  localparam int ST_DATA_LSB = 8;
  localparam int CFG_PAR_OFF = 0;

  // Reset values
  localparam logic [15:0] BAUD_RESET = 16'h04e2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ENABLE = 3'h1,
    OP_SYNC = 3'h2,
    OP_TX = 3'h3,
    OP_RX = 3'h4,
    OP_BREAK = 3'h5,
    OP_DBREAK = 3'h6,
    OP_TXRX = 3'h7
  } ohp_op_t;

  typedef struct packed {
    logic [7:0] data;
    logic err_start;
    logic err_parity;
    logic err_stop;
  } ohp_rx_t;

  typedef struct packed {
    logic [19:0] acc;
    logic tick;
  } ohp_frac_t;

  // Fractional sub-bit tick: sixteen ticks per div cycles, no drift
  function automatic ohp_frac_t ohp_frac_step(input logic [19:0] acc, input logic [15:0] div);
    logic [19:0] nxt;
    ohp_frac_t r;
    nxt = acc + 20'h00010;
    if (nxt >= {4'h0, div}) begin
      r.acc = nxt - {4'h0, div};
      r.tick = 1'b1;
    end else begin
      r.acc = nxt;
      r.tick = 1'b0;
    end
    return r;
  endfunction

endpackage

// ### logic/ohp_frame_rx.sv
// Oversampling frame receiver for the shared debug line
`timescale 1ns/1ps
`default_nettype none
module ohp_frame_rx (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_arm,
  input wire logic i_line,
  input wire logic [15:0] i_div,
  input wire logic i_par_off,
  output logic o_busy,
  output logic o_done,
  output ohp_pkg::ohp_rx_t o_res
);
  import ohp_pkg::*;

  logic active_q;
  logic [19:0] acc_q;
  logic [3:0] sub_q;
  logic [3:0] bit_q;
  logic [1:0] votes_q;
  logic [11:0] shreg_q;
  ohp_frac_t step;
  logic bitval;
  logic [11:0] fr;

  always_comb begin
    step = ohp_frac_step(acc_q, i_div);
    bitval = (votes_q == 2'd2) || (votes_q == 2'd1 && i_line);
    fr = {bitval, shreg_q[11:1]};
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      active_q <= 1'b0;
      acc_q <= '0;
      sub_q <= '0;
      bit_q <= '0;
      votes_q <= '0;
      shreg_q <= '0;
      o_done <= 1'b0;
      o_res <= '0;
    end else begin
      o_done <= 1'b0;
      if (!active_q) begin
        acc_q <= '0;
        sub_q <= '0;
        bit_q <= '0;
        votes_q <= '0;
        if (i_arm && !i_line) begin
          active_q <= 1'b1;
        end
      end else if (step.tick) begin
        acc_q <= step.acc;
        sub_q <= sub_q + 4'h1;
        if (sub_q >= VOTE_FIRST && sub_q < VOTE_LAST && i_line) begin
          votes_q <= votes_q + 2'd1;
        end
        if (sub_q == VOTE_LAST) begin
          shreg_q <= fr;
          votes_q <= '0;
          if (bit_q == 4'(FRAME_BITS - 1)) begin
            active_q <= 1'b0;
            o_done <= 1'b1;
            o_res.data <= fr[8:1];
            o_res.err_start <= fr[0];
            o_res.err_parity <= !i_par_off && ((^fr[8:1]) != fr[9]);
            o_res.err_stop <= !(fr[10] && fr[11]);
          end
        end
        if (sub_q == SUB_LAST) begin
          bit_q <= bit_q + 4'h1;
        end
      end else begin
        acc_q <= step.acc;
      end
    end
  end

  always_comb begin
    o_busy = active_q;
  end

endmodule // ohp_frame_rx
`default_nettype wire

// ### logic/ohp_host.sv
// Single-wire debug host: APB command registers, line driver, enable and break sequences
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ohp_host #(
  parameter int EN_WAIT_CYC = ohp_pkg::EN_WAIT_US * ohp_pkg::CLK_MHZ,
  parameter int RX_WAIT_CYC = ohp_pkg::RX_WAIT_US * ohp_pkg::CLK_MHZ,
  parameter int SYNC_WINDOW_CYC = ohp_pkg::SYNC_WINDOW_US * ohp_pkg::CLK_MHZ,
  parameter int BREAK_DEF_CYC = ohp_pkg::BREAK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_line_in,
  output logic o_line_out,
  output logic o_line_oe_n
);
  import ohp_pkg::*;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_EN_PULSE = 8'h02,
    S_EN_WAIT = 8'h04,
    S_TX = 8'h08,
    S_RX = 8'h10,
    S_BRK_LOW = 8'h20,
    S_BRK_GAP = 8'h40,
    S_BRK_LOW2 = 8'h80
  } ohp_state_t;

  ohp_state_t state_q;
  ohp_op_t op_q;
  logic [15:0] baud_q;
  logic [31:0] brk_q;
  logic par_off_q;
  logic busy_q;
  logic done_q;
  logic rxv_q;
  logic tmo_q;
  ohp_rx_t rxres_q;
  logic [31:0] cnt_q;
  logic [11:0] txsh_q;
  logic [3:0] txbit_q;
  logic [3:0] txsub_q;
  logic [19:0] txacc_q;
  logic rx_arm_q;
  logic acc_go;
  logic acc_wr;
  logic cmd_go;
  logic [2:0] cmd_op;
  logic [7:0] cmd_data;
  logic [31:0] rd_word;
  logic addr_ok;
  ohp_frac_t txstep;
  logic rx_busy;
  logic rx_done;
  ohp_rx_t rx_res;

  function automatic logic [11:0] ohp_frame(input logic [7:0] d);
    return {2'b11, ^d, d, 1'b0};
  endfunction

  always_comb begin
    acc_go = i_psel && i_penable && o_pready;
    acc_wr = acc_go && i_pwrite;
    cmd_op = i_pwdata[CMD_OP_LSB +: 3];
    cmd_data = i_pwdata[CMD_DATA_LSB +: 8];
    // Commands arriving while busy are dropped, not queued
    cmd_go = acc_wr && i_paddr == REG_CMD && !busy_q && cmd_op != OP_NONE;
    txstep = ohp_frac_step(txacc_q, baud_q);
    addr_ok = 1'b1;
    rd_word = '0;
    case (i_paddr)
      REG_CMD: rd_word = {29'h0, op_q};
      REG_BAUD: rd_word = {16'h0, baud_q};
      REG_BRK: rd_word = brk_q;
      REG_STATUS: begin
        rd_word[ST_BUSY] = busy_q;
        rd_word[ST_DONE] = done_q;
        rd_word[ST_RXV] = rxv_q;
        rd_word[ST_ESTART] = rxres_q.err_start;
        rd_word[ST_EPAR] = rxres_q.err_parity;
        rd_word[ST_ESTOP] = rxres_q.err_stop;
        rd_word[ST_TMO] = tmo_q;
        rd_word[ST_LINE] = i_line_in;
        rd_word[ST_DATA_LSB +: 8] = rxres_q.data;
      end
      REG_CFG: rd_word[CFG_PAR_OFF] = par_off_q;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB slave: one wait state, answer registered
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      o_prdata <= (i_psel && i_penable && !o_pready && !i_pwrite) ? rd_word : 32'h0;
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      baud_q <= BAUD_RESET;
      brk_q <= 32'(BREAK_DEF_CYC);
      par_off_q <= CFG_RESET[CFG_PAR_OFF];
    end else if (acc_wr) begin
      if (i_paddr == REG_BAUD) begin
        baud_q <= i_pwdata[15:0];
      end
      if (i_paddr == REG_BRK) begin
        brk_q <= i_pwdata;
      end
      if (i_paddr == REG_CFG) begin
        par_off_q <= i_pwdata[CFG_PAR_OFF];
      end
    end
  end

  // Sequencer
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= S_IDLE;
      op_q <= OP_NONE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rxv_q <= 1'b0;
      tmo_q <= 1'b0;
      rxres_q <= '0;
      cnt_q <= '0;
      txsh_q <= '1;
      txbit_q <= '0;
      txsub_q <= '0;
      txacc_q <= '0;
      rx_arm_q <= 1'b0;
      o_line_out <= 1'b0;
      o_line_oe_n <= 1'b1;
    end else begin
      o_line_out <= 1'b0;
      case (state_q)
        S_IDLE: begin
          o_line_oe_n <= 1'b1;
          rx_arm_q <= 1'b0;
          if (cmd_go) begin
            op_q <= ohp_op_t'(cmd_op);
            busy_q <= 1'b1;
            done_q <= 1'b0;
            tmo_q <= 1'b0;
            cnt_q <= '0;
            txacc_q <= '0;
            txbit_q <= '0;
            txsub_q <= '0;
            case (cmd_op)
              OP_ENABLE: begin
                state_q <= S_EN_PULSE;
                o_line_oe_n <= 1'b0;
              end
              OP_SYNC: begin
                txsh_q <= ohp_frame(SYNC_CHAR);
                state_q <= S_TX;
              end
              // instructions, disable too, go as bytes
              OP_TX, OP_TXRX: begin
                txsh_q <= ohp_frame(cmd_data);
                state_q <= S_TX;
              end
              OP_RX: begin
                rxv_q <= 1'b0;
                rx_arm_q <= 1'b1;
                state_q <= S_RX;
              end
              OP_BREAK, OP_DBREAK: begin
                o_line_oe_n <= 1'b0;
                state_q <= S_BRK_LOW;
              end
              default: begin
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        S_EN_PULSE: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == 32'(EN_PULSE_CYC - 1)) begin
            o_line_oe_n <= 1'b1;
            cnt_q <= '0;
            state_q <= S_EN_WAIT;
          end
        end
        S_EN_WAIT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q > 32'h2 && i_line_in) begin
            txsh_q <= ohp_frame(SYNC_CHAR);
            cnt_q <= '0;
            state_q <= S_TX;
          end else if (cnt_q == 32'(EN_WAIT_CYC - 1)) begin
            tmo_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_TX: begin
          o_line_oe_n <= txsh_q[0];
          txacc_q <= txstep.acc;
          if (txstep.tick) begin
            txsub_q <= txsub_q + 4'h1;
            if (txsub_q == SUB_LAST) begin
              txsh_q <= {1'b1, txsh_q[11:1]};
              txbit_q <= txbit_q + 4'h1;
              if (txbit_q == 4'(FRAME_BITS - 1)) begin
                o_line_oe_n <= 1'b1;
                cnt_q <= '0;
                if (op_q == OP_TXRX) begin
                  rxv_q <= 1'b0;
                  rx_arm_q <= 1'b1;
                  state_q <= S_RX;
                end else begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  state_q <= S_IDLE;
                end
              end
            end
          end
        end
        S_RX: begin
          o_line_oe_n <= 1'b1;
          cnt_q <= cnt_q + 32'h1;
          if (rx_done) begin
            rxres_q <= rx_res;
            rxv_q <= 1'b1;
            rx_arm_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (!rx_busy && cnt_q >= 32'(RX_WAIT_CYC - 1)) begin
            tmo_q <= 1'b1;
            rx_arm_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_BRK_LOW, S_BRK_LOW2: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= brk_q - 32'h1) begin
            o_line_oe_n <= 1'b1;
            cnt_q <= '0;
            if (state_q == S_BRK_LOW && op_q == OP_DBREAK) begin
              state_q <= S_BRK_GAP;
            end else begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_BRK_GAP: begin
          // gap longer than two slow bits
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= {2'b00, brk_q[31:2]}) begin
            o_line_oe_n <= 1'b0;
            cnt_q <= '0;
            state_q <= S_BRK_LOW2;
          end
        end
        default: begin
          o_line_oe_n <= 1'b1;
          busy_q <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ohp_frame_rx u_rx (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_arm(rx_arm_q),
    .i_line(i_line_in),
    .i_div(baud_q),
    .i_par_off(par_off_q),
    .o_busy(rx_busy),
    .o_done(rx_done),
    .o_res(rx_res)
  );

endmodule // ohp_host
`default_nettype wire

// ### verification/ohp_host_sva.sv
// Port-level assertions for the single-wire debug host
`timescale 1ns/1ps
`default_nettype none
module ohp_host_sva (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_line_in,
  input wire logic o_line_out,
  input wire logic o_line_oe_n
);
  import ohp_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  logic mapped;
  assign mapped = i_paddr inside {REG_CMD, REG_BAUD, REG_BRK, REG_STATUS, REG_CFG};
  // Command accepted while the line is released
  sequence s_cmd(logic [2:0] op);
    o_pready && i_pwrite && (i_paddr == REG_CMD) && (i_pwdata[2:0] == op) && o_line_oe_n;
  endsequence
  sequence s_access_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");
  a_pready_time: assert property (s_access_wait |=> o_pready)
    else $error("pready late after access edge");
  a_pready_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_slverr_map: assert property (o_pready |-> o_pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_slverr_only: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_write_zero: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
    else $error("prdata not zero on write");
  a_line_drive_low: assert property (o_line_out == 1'b0)
    else $error("line driven high");
  a_tx_start: assert property (s_cmd(OP_TX) |-> ##[1:2] !o_line_oe_n)
    else $error("start bit missing after send command");
  a_enable_pulse: assert property (s_cmd(OP_ENABLE) |-> ##[1:2] (!o_line_oe_n) [*8])
    else $error("enable pulse too short");
  a_enable_release: assert property (s_cmd(OP_ENABLE) |->
    ##25 !o_line_oe_n ##[1:100] o_line_oe_n)
    else $error("enable pulse not released in time");
endmodule // ohp_host_sva
bind ohp_host ohp_host_sva u_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_line_in(i_line_in),
  .o_line_out(o_line_out), .o_line_oe_n(o_line_oe_n));
`default_nettype wire

// ### verification/ohp_dev_model.sv
// Behavioural target device on the shared debug line
`timescale 1ns/1ps
`default_nettype none
module ohp_dev_model #(
  parameter int BIT_CYC = 64,
  parameter int HOLD_CYC = 120
) (
  input wire logic i_sys_clk,
  input wire logic i_line,
  input wire logic i_ack_en,
  input wire logic [7:0] i_ack_val,
  output logic o_pull_n,
  output logic [7:0] o_last,
  output logic o_err,
  output logic [7:0] o_breaks
);
  logic [11:0] f;
  logic on;
  logic synced;
  task automatic send(input logic [7:0] b);
    logic [11:0] w;
    w = {2'b11, ^b, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      o_pull_n <= w[i];
      repeat (BIT_CYC) @(posedge i_sys_clk);
    end
  endtask
  initial begin
    // released pin rests high through the pull-up
    o_pull_n = 1'b1;
    o_last = 8'h00;
    o_err = 1'b0;
    o_breaks = 8'h00;
    on = 1'b0;
    synced = 1'b0;
    forever begin
      @(posedge i_sys_clk);
      if (i_line === 1'b0 && !on) begin
        // hold line low until clock ready
        o_pull_n <= 1'b0;
        repeat (HOLD_CYC) @(posedge i_sys_clk);
        o_pull_n <= 1'b1;
        // pin stays with the port once enabled, unless the first byte after enable is not a sync
        on = 1'b1;
        synced = 1'b0;
      end else if (i_line === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 12; i++) begin
          f[i] = i_line;
          if (i < 11) repeat (BIT_CYC) @(posedge i_sys_clk);
        end
        if (f == 12'h000) begin
          // break clears error state, rate fixed
          o_breaks <= o_breaks + 8'h01;
          o_err <= 1'b0;
          while (i_line !== 1'b1) @(posedge i_sys_clk);
        end else begin
          // checks incl. parity, sticky until break
          o_err <= o_err | f[0] | (^f[9:1]) | !(&f[11:10]);
          o_last <= f[8:1];
          // bad first sync disables the port
          if (!synced && f[8:1] != ohp_pkg::SYNC_CHAR) begin
            on = 1'b0;
          end
          synced = 1'b1;
          if (i_ack_en && f[8:1] != ohp_pkg::SYNC_CHAR) begin
            repeat (2 * BIT_CYC) @(posedge i_sys_clk);
            send(i_ack_val);
          end
        end
      end
    end
  end
endmodule // ohp_dev_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the single-wire debug host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ohp_pkg::*;
  localparam logic [31:0] BAUD = 32'h0000_0040;
  localparam logic [31:0] BRK = 32'h0000_0320;
  localparam int BRK_DEF = 500;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, lout, oe_n, pull_n, ack_en, derr, line, er;
  logic [7:0] paddr, dlast, dbrk, ack_val;
  logic [31:0] pwdata, prdata, rd, s;
  logic [7:0] tbl [4] = '{8'h00, 8'ha5, 8'hff, 8'h3c};
  int num_errors, n_tests;
  // Wired-and line with pull-up
  assign line = oe_n & pull_n;
  ohp_host #(.EN_WAIT_CYC(200), .RX_WAIT_CYC(2000),
    .BREAK_DEF_CYC(BRK_DEF)) u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_line_in(line), .o_line_out(lout),
    .o_line_oe_n(oe_n));
  ohp_dev_model u_dev (.i_sys_clk(clk), .i_line(line),
    .i_ack_en(ack_en), .i_ack_val(ack_val), .o_pull_n(pull_n), .o_last(dlast), .o_err(derr),
    .o_breaks(dbrk));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Issue a command and poll until it completes
  task automatic op(input ohp_op_t o, input logic [7:0] b);
    logic dn;
    dn = 1'b0;
    apb(1'b1, REG_CMD, {16'h0, b, 5'h0, o}, rd, er);
    for (int i = 0; i < 3000 && !dn; i++) begin
      apb(1'b0, REG_STATUS, 32'h0, s, er);
      dn = (s[ST_BUSY] === 1'b0) && (s[ST_DONE] === 1'b1);
    end
    chk("op done", dn, 1'b1);
  endtask
  task automatic results;
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #(8 * 40000);
    num_errors++;
    results;
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ack_en = 1'b0;
    ack_val = 8'h40;
    num_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_BAUD, 32'h0, rd, er);
    chk("baud reset", rd, {16'h0, BAUD_RESET});
    apb(1'b0, REG_CFG, 32'h0, rd, er);
    chk("cfg reset", rd, CFG_RESET);
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("status reset", rd[6:0], 7'h00);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk("unmapped read err", er, 1'b1);
    apb(1'b1, 8'h20, 32'h1, rd, er);
    chk("unmapped write err", er, 1'b1);
    apb(1'b1, REG_BAUD, BAUD, rd, er);
    chk("mapped write err", er, 1'b0);
    apb(1'b1, REG_BRK, BRK, rd, er);
    apb(1'b0, REG_BAUD, 32'h0, rd, er);
    chk("baud readback", rd, BAUD);
    apb(1'b1, REG_CFG, 32'h1, rd, er);
    apb(1'b0, REG_CFG, 32'h0, rd, er);
    chk("cfg readback", rd, 32'h1);
    apb(1'b1, REG_CFG, 32'h0, rd, er);
    op(OP_ENABLE, 8'h00);
    chk("enable timeout", s[ST_TMO], 1'b0);
    chk("first sync", dlast, SYNC_CHAR);
    foreach (tbl[i]) begin
      op(OP_TX, tbl[i]);
      chk("tx byte", dlast, tbl[i]);
      chk("frame error", derr, 1'b0);
    end
    chk("idle line", s[ST_LINE], 1'b1);
    ack_en <= 1'b1;
    op(OP_TXRX, 8'h44);
    chk("ack byte", s[15:8], 8'h40);
    chk("ack valid", s[ST_RXV], 1'b1);
    chk("ack errors", s[ST_ESTOP:ST_ESTART], 3'h0);
    // Let the reply's last stop bit finish first
    repeat (128) @(posedge clk);
    ack_val <= 8'hc3;
    apb(1'b1, REG_CFG, 32'h1, rd, er);
    op(OP_TXRX, 8'h0f);
    chk("ack byte 2", s[15:8], 8'hc3);
    chk("ack errors 2", s[ST_ESTOP:ST_ESTART], 3'h0);
    apb(1'b1, REG_CFG, 32'h0, rd, er);
    ack_en <= 1'b0;
    op(OP_RX, 8'h00);
    chk("rx timeout", s[ST_TMO], 1'b1);
    op(OP_SYNC, 8'h00);
    chk("sync byte", dlast, SYNC_CHAR);
    op(OP_BREAK, 8'h00);
    chk("single break", dbrk, 8'h01);
    op(OP_DBREAK, 8'h00);
    chk("double break", dbrk, 8'h03);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_BRK, 32'h0, rd, er);
    chk("brk reset", rd, 32'(BRK_DEF));
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("status after reset", rd[6:0], 7'h00);
    results;
  end
endmodule // tb_top
`default_nettype wire
